/* src/comparator_pkg.sv */
// shared constants, field layouts and types of the comparator wrapper
// assumes one peripheral clock and an 8-bit register port of 3 address bits
package comparator_pkg;

    // ********************************************************************
    // register offsets
    // ********************************************************************
    localparam logic [2:0] OFS_CONTROL_A        = 3'h0;
    localparam logic [2:0] OFS_INPUT_SELECT     = 3'h2;
    localparam logic [2:0] OFS_REFERENCE_LEVEL  = 3'h4;
    localparam logic [2:0] OFS_INTERRUPT_ENABLE = 3'h6;
    localparam logic [2:0] OFS_STATUS           = 3'h7;

    // ********************************************************************
    // field positions
    // ********************************************************************
    localparam int BIT_ENABLE         = 0;
    localparam int BIT_HYS_LSB        = 1;
    localparam int BIT_LOW_POWER      = 3;
    localparam int BIT_EDGE_LSB       = 4;
    localparam int BIT_OUTPUT_PAD     = 6;
    localparam int BIT_RUN_IN_STANDBY = 7;
    localparam int BIT_NEG_LSB        = 0;
    localparam int BIT_POS_LSB        = 3;
    localparam int BIT_INVERT         = 7;
    localparam int BIT_COMPARE_IRQ    = 0;
    localparam int BIT_STATE          = 4;

    // writable bits of input_select, the rest read as zero
    localparam logic [7:0] INPUT_SELECT_MASK = 8'h9B;

    // ********************************************************************
    // values after reset
    // ********************************************************************
    localparam logic [7:0] RST_CONTROL_A        = 8'h00;
    localparam logic [7:0] RST_INPUT_SELECT     = 8'h00;
    localparam logic [7:0] RST_REFERENCE_LEVEL  = 8'hFF;
    localparam logic [7:0] RST_INTERRUPT_ENABLE = 8'h00;
    localparam logic [7:0] RST_READ_DATA        = 8'h00;

    // ********************************************************************
    // timing
    // ********************************************************************
    localparam int CLK_PERIOD_NS   = 20;
    localparam int STARTUP_TIME_NS = 2500;
    // longest output-invalid time after enable, rounded down
    localparam int STARTUP_CYCLES  = STARTUP_TIME_NS / CLK_PERIOD_NS;
    localparam int SYNC_STAGES     = 3;

    // ********************************************************************
    // types
    // ********************************************************************
    typedef enum logic [1:0] {
        any_edge      = 2'b00,
        reserved_edge = 2'b01,
        falling_edge  = 2'b10,
        rising_edge   = 2'b11
    } edge_mode_t;

    typedef enum logic [1:0] {
        hys_none   = 2'b00,
        hys_small  = 2'b01,
        hys_medium = 2'b10,
        hys_large  = 2'b11
    } hysteresis_t;

    // negative code 3 selects the internal divider reference
    typedef struct packed {
        logic        enable;
        logic        low_power;
        hysteresis_t hysteresis;
        logic [1:0]  pos_sel;
        logic [1:0]  neg_sel;
        logic [7:0]  ref_level;
    } core_ctrl_t;

endpackage

/* src/compare_sync.sv */
// three-stage synchroniser with agreement filter for the comparator level
// assumes the input is asynchronous to mclk
`timescale 1ns/1ps
`default_nettype none
module compare_sync
    import comparator_pkg::*;
(
    // clock and reset
    input  wire logic mclk,
    input  wire logic rstn,
    // level in and filtered level out
    input  wire logic level_async,
    output logic      level_sync
);

    logic [SYNC_STAGES-1:0] stage_q;
    logic [SYNC_STAGES-1:0] stage_d;
    logic                   level_q;
    logic                   level_d;

    // stage 0 is read only by stage 1
    always_comb begin
        stage_d = {stage_q[SYNC_STAGES-2:0], level_async};
        level_d = level_q;
        if (stage_q[1] == stage_q[2]) begin
            level_d = stage_q[2];
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            stage_q <= '0;
            level_q <= 1'b0;
        end else begin
            stage_q <= stage_d;
            level_q <= level_d;
        end
    end

    // filtered level leaves before level_q so the state lags three edges
    assign level_sync = level_d;

endmodule
`default_nettype wire

/* src/compare_edge.sv */
// edge detector that qualifies transitions by the selected edge mode
// assumes a level already synchronous to mclk
`timescale 1ns/1ps
`default_nettype none
module compare_edge
    import comparator_pkg::*;
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rstn,
    // level and mode
    input  wire logic       level,
    input  wire edge_mode_t mode,
    // one-cycle hit
    output logic            hit
);

    logic prev_q;
    logic prev_d;

    always_comb begin
        prev_d = level;
        case (mode)
            any_edge:     hit = level ^ prev_q;
            falling_edge: hit = prev_q & ~level;
            rising_edge:  hit = ~prev_q & level;
            // reserved code never fires
            default:      hit = 1'b0;
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
        end
    end

endmodule
`default_nettype wire

/* src/comparator_control.sv */
// register bank, sleep gating, status and interrupt of the comparator
// assumes sleep state inputs come from logic on mclk
// assumes the analog core drives compare_raw asynchronously
`timescale 1ns/1ps
`default_nettype none

// How it works
// - edge_select: 0 both edges, 2 falling, 3 rising, 1 reserved
// - matching output transition sets the compare flag in status
// - irq high while enable and flag both set, until flag cleared
// - interrupt_enable bit 0 at offset 0x06 enables the interrupt
// - hysteresis_select drives core: none, small, medium, large
// - control_a bit 3 drives low-power mode of the core
// - output reaches pad only when output_pad_enable bit 6 set
// - control_a bit 0 enables; control_a and input_select reset to zero
// - standby compares only with run_in_standby; flags then frozen
// - standby without run_in_standby disables the comparator
// - idle sleep keeps full normal operation
// - power-down disables comparator and pad output always
// - raw output offered as unsynchronised event while enabled
// - registers at 0x00, 0x02, 0x04, 0x06, 0x07; others reserved
// - invert bit flips output for status, edges, events and pad
// - positive select pins 0..3; negative pins 0..2 or reference
// - status state bit follows output after three-cycle sync
// - writing one to flag clears it, zero does nothing
module comparator_control
    import comparator_pkg::*;
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rstn,
    // register port
    input  wire logic [2:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // sleep state
    input  wire logic       sleep_idle,
    input  wire logic       sleep_standby,
    input  wire logic       sleep_power_down,
    // analog core
    input  wire logic       compare_raw,
    output core_ctrl_t      core_ctrl,
    // pad, event and interrupt
    output logic            pad_out,
    output logic            pad_oe,
    output logic            event_out,
    output logic            irq
);

    // ********************************************************************
    // register state
    // ********************************************************************
    logic [7:0] control_a_q;
    logic [7:0] control_a_d;
    logic [7:0] input_select_q;
    logic [7:0] input_select_d;
    logic [7:0] reference_level_q;
    logic [7:0] reference_level_d;
    logic       interrupt_enable_q;
    logic       interrupt_enable_d;
    logic       flag_q;
    logic       flag_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    // ********************************************************************
    // decoded fields
    // ********************************************************************
    logic        enable_bit;
    logic        run_in_standby;
    logic        output_pad_enable;
    logic        invert;
    edge_mode_t  edge_select;
    hysteresis_t hysteresis_select;
    logic        active;
    logic        clock_running;
    logic        compare_out;
    logic        state_sync;
    logic        edge_hit;
    logic        flag_set;
    logic        flag_clear;

    assign enable_bit        = control_a_q[BIT_ENABLE];
    assign run_in_standby    = control_a_q[BIT_RUN_IN_STANDBY];
    assign output_pad_enable = control_a_q[BIT_OUTPUT_PAD];
    assign invert            = input_select_q[BIT_INVERT];
    assign edge_select       = edge_mode_t'(control_a_q[BIT_EDGE_LSB +: 2]);
    assign hysteresis_select = hysteresis_t'(control_a_q[BIT_HYS_LSB +: 2]);

    // ********************************************************************
    // sleep gating
    // ********************************************************************
    // idle is not a gating term: the block runs as when awake
    always_comb begin
        active = enable_bit;
        if (sleep_power_down) begin
            active = 1'b0;
        end else if (sleep_standby && !run_in_standby) begin
            active = 1'b0;
        end
        // peripheral clock is stopped in standby and power-down
        clock_running = !sleep_standby && !sleep_power_down;
    end

    // ********************************************************************
    // core controls
    // ********************************************************************
    always_comb begin
        core_ctrl.enable     = active;
        core_ctrl.low_power  = control_a_q[BIT_LOW_POWER];
        core_ctrl.hysteresis = hysteresis_select;
        core_ctrl.pos_sel    = input_select_q[BIT_POS_LSB +: 2];
        core_ctrl.neg_sel    = input_select_q[BIT_NEG_LSB +: 2];
        core_ctrl.ref_level  = reference_level_q;
    end

    // ********************************************************************
    // output path
    // ********************************************************************
    // pad and event stay asynchronous so standby operation needs no clock
    assign compare_out = compare_raw ^ invert;
    assign event_out   = active & compare_out;
    assign pad_oe      = active & output_pad_enable;
    assign pad_out     = pad_oe & compare_out;

    compare_sync u_sync (
        .mclk        (mclk),
        .rstn        (rstn),
        .level_async (compare_out),
        .level_sync  (state_sync)
    );

    compare_edge u_edge (
        .mclk  (mclk),
        .rstn  (rstn),
        .level (state_sync),
        .mode  (edge_select),
        .hit   (edge_hit)
    );

    // ********************************************************************
    // register writes and flag
    // ********************************************************************
    always_comb begin
        control_a_d        = control_a_q;
        input_select_d     = input_select_q;
        reference_level_d  = reference_level_q;
        interrupt_enable_d = interrupt_enable_q;
        flag_clear         = 1'b0;
        if (reg_wr) begin
            case (reg_addr)
                OFS_CONTROL_A: begin
                    control_a_d = reg_wdata;
                end
                OFS_INPUT_SELECT: begin
                    input_select_d = reg_wdata & INPUT_SELECT_MASK;
                end
                OFS_REFERENCE_LEVEL: begin
                    reference_level_d = reg_wdata;
                end
                OFS_INTERRUPT_ENABLE: begin
                    interrupt_enable_d = reg_wdata[BIT_COMPARE_IRQ];
                end
                OFS_STATUS: begin
                    flag_clear = reg_wdata[BIT_COMPARE_IRQ];
                end
                default: begin
                    control_a_d = control_a_q;
                end
            endcase
        end
        // disabled core gives no valid edges; frozen while clock is off
        flag_set = edge_hit && enable_bit && clock_running;
        // a set in the clearing cycle wins so no event is lost
        flag_d = flag_set | (flag_q & ~flag_clear);
    end

    // ********************************************************************
    // read path
    // ********************************************************************
    always_comb begin
        rdata_d = RST_READ_DATA;
        if (reg_rd) begin
            case (reg_addr)
                OFS_CONTROL_A:        rdata_d = control_a_q;
                OFS_INPUT_SELECT:     rdata_d = input_select_q;
                OFS_REFERENCE_LEVEL:  rdata_d = reference_level_q;
                OFS_INTERRUPT_ENABLE: begin
                    rdata_d[BIT_COMPARE_IRQ] = interrupt_enable_q;
                end
                OFS_STATUS: begin
                    rdata_d[BIT_STATE]       = state_sync;
                    rdata_d[BIT_COMPARE_IRQ] = flag_q;
                end
                default:              rdata_d = RST_READ_DATA;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            control_a_q        <= RST_CONTROL_A;
            input_select_q     <= RST_INPUT_SELECT;
            reference_level_q  <= RST_REFERENCE_LEVEL;
            interrupt_enable_q <= RST_INTERRUPT_ENABLE[BIT_COMPARE_IRQ];
            flag_q             <= 1'b0;
            rdata_q            <= RST_READ_DATA;
        end else begin
            control_a_q        <= control_a_d;
            input_select_q     <= input_select_d;
            reference_level_q  <= reference_level_d;
            interrupt_enable_q <= interrupt_enable_d;
            flag_q             <= flag_d;
            rdata_q            <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign irq       = interrupt_enable_q & flag_q;

    // ********************************************************************
    // assertions
    // ********************************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    a_irq_follows_flag: assert property (
        irq == (interrupt_enable_q && flag_q)
    ) else $error("irq does not follow enable and flag");

    a_irq_drops_clear: assert property (
        $fell(flag_q) |-> !irq
    ) else $error("irq still high after flag cleared");

    a_irq_on_set: assert property (
        flag_set && interrupt_enable_q && !reg_wr |=> irq
    ) else $error("enabled flag did not raise irq");

    a_flag_set_edge: assert property (
        flag_set |=> flag_q
    ) else $error("matching edge did not set flag");

    a_reserved_quiet: assert property (
        edge_select == reserved_edge |-> !edge_hit
    ) else $error("reserved edge code produced an edge");

    a_flag_write_clear: assert property (
        reg_wr && reg_addr == OFS_STATUS && reg_wdata[0] && !flag_set
        |=> !flag_q
    ) else $error("writing one did not clear flag");

    a_flag_write_zero: assert property (
        reg_wr && reg_addr == OFS_STATUS && !reg_wdata[0] && flag_q
        |=> flag_q
    ) else $error("writing zero changed flag");

    a_int_enable_write: assert property (
        reg_wr && reg_addr == OFS_INTERRUPT_ENABLE
        |=> interrupt_enable_q == $past(reg_wdata[0])
    ) else $error("interrupt enable not written");

    a_read_control: assert property (
        reg_rd && reg_addr == OFS_CONTROL_A && !reg_wr
        |=> reg_rdata == $past(control_a_q)
        ##1 reg_rdata == 8'h00 || $past(reg_rd)
    ) else $error("control_a read wrong");

    a_state_delay: assert property (
        state_sync != $past(state_sync) |-> state_sync == $past(compare_out, 3)
    ) else $error("state bit not three cycles behind output");

    a_power_down_off: assert property (
        sleep_power_down |-> !core_ctrl.enable && !pad_oe
    ) else $error("core or pad active in power-down");

    a_standby_default: assert property (
        sleep_standby && !run_in_standby |-> !core_ctrl.enable
    ) else $error("core enabled in standby without run bit");

    a_idle_normal: assert property (
        sleep_idle && !sleep_standby && !sleep_power_down
        |-> core_ctrl.enable == enable_bit
    ) else $error("idle sleep changed comparator enable");

    a_standby_frozen: assert property (
        sleep_standby && !flag_q ##1 sleep_standby |-> !flag_q
    ) else $error("flag updated in standby");

    a_pad_gate: assert property (
        pad_oe |-> output_pad_enable && enable_bit
    ) else $error("pad driven without output pad enable");

    a_ref_follow: assert property (
        reg_wr && reg_addr == OFS_REFERENCE_LEVEL
        |=> core_ctrl.ref_level == $past(reg_wdata)
    ) else $error("reference level not updated");

endmodule
`default_nettype wire

/* dv/comparator_core_model.sv */
// behavioural analog comparator core with its reference divider
// assumes pin levels come from the bench as 8-bit codes
`timescale 1ns/1ps
`default_nettype none
module comparator_core_model
    import comparator_pkg::*;
(
    // pacing clock
    input  wire logic            mclk,
    // control from the wrapper and pin levels
    input  wire core_ctrl_t      core_ctrl,
    input  wire logic [3:0][7:0] pos_lv,
    input  wire logic [2:0][7:0] neg_lv,
    // decision
    output logic                 compare_raw
);
    // ****************************************************************
    // input selection and threshold
    // ****************************************************************
    logic [7:0] vp;
    logic [7:0] vn;
    logic [8:0] hys;
    int         warm;
    initial compare_raw = 1'b0;
    initial warm = 0;
    assign vp = pos_lv[core_ctrl.pos_sel];
    assign vn = (core_ctrl.neg_sel == 2'h3) ? core_ctrl.ref_level
                                            : neg_lv[core_ctrl.neg_sel];
    assign hys = {7'h00, core_ctrl.hysteresis} * 9'h004;
    // ****************************************************************
    // decision, garbage while off or warming up
    // ****************************************************************
    // toggling, not holding, so a stale level can never pass for valid
    always @(negedge mclk) begin
        if (!core_ctrl.enable) begin
            warm <= STARTUP_CYCLES;
            compare_raw <= ~compare_raw;
        end else if (warm != 0) begin
            warm <= warm - 1;
            compare_raw <= ~compare_raw;
        end else if ({1'b0, vp} > {1'b0, vn} + hys) begin
            compare_raw <= 1'b1;
        end else if ({1'b0, vp} + hys < {1'b0, vn}) begin
            compare_raw <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* dv/comparator_control_bench.sv */
// self-checking bench of the comparator wrapper
// assumes the core model file and the package are compiled first
`timescale 1ns/1ps
`default_nettype none
module comparator_control_bench
    import comparator_pkg::*;
();
    logic            mclk;
    logic            rstn;
    logic [2:0]      reg_addr;
    logic [7:0]      reg_wdata;
    logic            reg_wr;
    logic            reg_rd;
    logic [7:0]      reg_rdata;
    logic            sleep_idle;
    logic            sleep_standby;
    logic            sleep_power_down;
    logic            compare_raw;
    core_ctrl_t      core_ctrl;
    logic            pad_out;
    logic            pad_oe;
    logic            event_out;
    logic            irq;
    logic [3:0][7:0] pos_lv;
    logic [2:0][7:0] neg_lv;
    logic [7:0]      d;
    int              num_errors;
    int              total_checks;

    comparator_control comparator_control_i (
        .mclk             (mclk),
        .rstn             (rstn),
        .reg_addr         (reg_addr),
        .reg_wdata        (reg_wdata),
        .reg_wr           (reg_wr),
        .reg_rd           (reg_rd),
        .reg_rdata        (reg_rdata),
        .sleep_idle       (sleep_idle),
        .sleep_standby    (sleep_standby),
        .sleep_power_down (sleep_power_down),
        .compare_raw      (compare_raw),
        .core_ctrl        (core_ctrl),
        .pad_out          (pad_out),
        .pad_oe           (pad_oe),
        .event_out        (event_out),
        .irq              (irq)
    );
    comparator_core_model comparator_core_model_i (
        .mclk        (mclk),
        .core_ctrl   (core_ctrl),
        .pos_lv      (pos_lv),
        .neg_lv      (neg_lv),
        .compare_raw (compare_raw)
    );

    // ****************************************************************
    // access tasks
    // ****************************************************************
    always #(CLK_PERIOD_NS / 2) mclk = ~mclk;
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // output is garbage after enabling, so wait it out and drop the flag
    task automatic warm_clear;
        wait_n(STARTUP_CYCLES + 8);
        wr(OFS_STATUS, 8'h01);
    endtask
    task automatic print_verdict;
        if (num_errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        #(CLK_PERIOD_NS * 20000);
        num_errors++;
        print_verdict;
    end

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        mclk = 1'b0;
        rstn = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        sleep_idle = 1'b0;
        sleep_standby = 1'b0;
        sleep_power_down = 1'b0;
        pos_lv = '0;
        neg_lv = {8'hFF, 8'hFF, 8'hFF};
        num_errors = 0;
        total_checks = 0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        for (int a = 0; a < 8; a++) begin
            rd(3'(a), d);
            check("reset", d, (a == 4) ? RST_REFERENCE_LEVEL : 8'h00);
        end
        for (int a = 1; a < 6; a += 2) begin
            wr(3'(a), 8'hFF);
            rd(3'(a), d);
            check("reserved", d, 8'h00);
        end
        wr(OFS_INPUT_SELECT, 8'hFF);
        rd(OFS_INPUT_SELECT, d);
        check("input_select", d, INPUT_SELECT_MASK);
        wr(OFS_INTERRUPT_ENABLE, 8'hFF);
        rd(OFS_INTERRUPT_ENABLE, d);
        check("interrupt_enable", d, 8'h01);
        wr(OFS_REFERENCE_LEVEL, 8'h80);
        check("ref_level", core_ctrl.ref_level, 8'h80);
        for (int h = 0; h < 4; h++) begin
            wr(OFS_CONTROL_A, {4'h0, 1'b1, 2'(h), 1'b0});
            check("hysteresis", 8'(core_ctrl.hysteresis), 8'(h));
            check("low_power", 8'(core_ctrl.low_power), 8'h01);
            check("enable", 8'(core_ctrl.enable), 8'h00);
        end
        wr(OFS_CONTROL_A, 8'h01);
        check("enable", 8'(core_ctrl.enable), 8'h01);
        warm_clear;
        for (int p = 0; p < 4; p++) begin
            pos_lv <= 32'h0000_00F0 << (8 * p);
            wr(OFS_INPUT_SELECT, {3'h0, 2'(p), 3'h3});
            wait_n(8);
            rd(OFS_STATUS, d);
            check("pos pin", 8'(d[4]), 8'h01);
        end
        pos_lv <= 32'h0000_0080;
        neg_lv <= {8'hFF, 8'h10, 8'hFF};
        wr(OFS_INPUT_SELECT, 8'h01);
        wait_n(8);
        rd(OFS_STATUS, d);
        check("neg pin", 8'(d[4]), 8'h01);
        wr(OFS_INPUT_SELECT, 8'h03);
        // edge modes in order any, reserved, falling, rising
        for (int m = 0; m < 4; m++) begin
            pos_lv <= 32'h0000_0010;
            wr(OFS_CONTROL_A, {2'b00, 2'(m), 4'h1});
            wait_n(8);
            wr(OFS_STATUS, 8'h01);
            pos_lv <= 32'h0000_00F0;
            wait_n(8);
            rd(OFS_STATUS, d);
            check("flag rise", 8'(d[0]), 8'(m == 0 || m == 3));
            check("irq rise", 8'(irq), 8'(m == 0 || m == 3));
            wr(OFS_STATUS, 8'h01);
            pos_lv <= 32'h0000_0010;
            wait_n(8);
            rd(OFS_STATUS, d);
            check("flag fall", 8'(d[0]), 8'(m == 0 || m == 2));
        end
        wr(OFS_CONTROL_A, 8'h41);
        wait_n(8);
        wr(OFS_STATUS, 8'h01);
        pos_lv <= 32'h0000_00F0;
        wait_n(8);
        wr(OFS_STATUS, 8'hFE);
        rd(OFS_STATUS, d);
        check("flag kept", d, 8'h11);
        check("pad_oe", 8'(pad_oe), 8'h01);
        check("pad_out", 8'(pad_out), 8'h01);
        check("event", 8'(event_out), 8'h01);
        wr(OFS_STATUS, 8'h01);
        rd(OFS_STATUS, d);
        check("flag cleared", d, 8'h10);
        check("irq cleared", 8'(irq), 8'h00);
        wr(OFS_INPUT_SELECT, 8'h83);
        wait_n(8);
        rd(OFS_STATUS, d);
        check("inverted state", 8'(d[4]), 8'h00);
        check("inverted pad", 8'(pad_out), 8'h00);
        check("inverted event", 8'(event_out), 8'h00);
        wr(OFS_INPUT_SELECT, 8'h03);
        wr(OFS_CONTROL_A, 8'h01);
        check("pad off", 8'(pad_oe), 8'h00);
        @(posedge mclk) sleep_standby <= 1'b1;
        wait_n(1);
        check("standby", 8'(core_ctrl.enable), 8'h00);
        check("standby event", 8'(event_out), 8'h00);
        @(posedge mclk) sleep_standby <= 1'b0;
        wr(OFS_CONTROL_A, 8'hC1);
        warm_clear;
        @(posedge mclk) sleep_standby <= 1'b1;
        pos_lv <= 32'h0000_0010;
        wait_n(8);
        pos_lv <= 32'h0000_00F0;
        wait_n(8);
        check("run standby", 8'(core_ctrl.enable), 8'h01);
        check("standby event", 8'(event_out), 8'h01);
        check("standby pad", 8'(pad_oe), 8'h01);
        rd(OFS_STATUS, d);
        check("flag frozen", 8'(d[0]), 8'h00);
        @(posedge mclk) sleep_standby <= 1'b0;
        sleep_power_down <= 1'b1;
        wait_n(1);
        check("power down", 8'(core_ctrl.enable), 8'h00);
        check("power down pad", 8'(pad_oe), 8'h00);
        check("power down event", 8'(event_out), 8'h00);
        @(posedge mclk) sleep_power_down <= 1'b0;
        sleep_idle <= 1'b1;
        warm_clear;
        check("idle", 8'(core_ctrl.enable), 8'h01);
        pos_lv <= 32'h0000_0010;
        wait_n(8);
        rd(OFS_STATUS, d);
        check("idle flag", 8'(d[0]), 8'h01);
        check("idle irq", 8'(irq), 8'h01);
        wr(OFS_INTERRUPT_ENABLE, 8'h00);
        check("irq masked", 8'(irq), 8'h00);
        print_verdict;
    end
endmodule
`default_nettype wire
